// >>> rtl/timer_event_defines.svh
`ifndef TIMER_EVENT_DEFINES_SVH
`define TIMER_EVENT_DEFINES_SVH
// channel and source counts
`define CH_NUM 5
`define MATCH_NUM 16
`define OVF_NUM 5
`define UNF_NUM 2
`define XFER_NUM 17
// counter width and wrap points
`define CNT_W 16
`define CNT_MAX 16'hFFFF
`define CNT_MIN 16'h0000
`define CNT_ONE 16'h0001
// reset values
`define FLAG_RST 1'b0
`define PIN_RST 1'b0
// pin level codes of the pin i/o control field
`define PIN_KEEP 2'h0
`define PIN_LOW 2'h1
`define PIN_HIGH 2'h2
`define PIN_TOGGLE 2'h3
`endif

// >>> rtl/timer_event_pkg.sv
package timer_event_pkg;
    // pending source inside one channel, highest priority first
    typedef enum logic [2:0] {
        SRC_A = 3'h0,
        SRC_B = 3'h1,
        SRC_C = 3'h2,
        SRC_D = 3'h3,
        SRC_OVF = 3'h4,
        SRC_UNF = 3'h5,
        SRC_NONE = 3'h7
    } pend_src_t;
    // channel number
    typedef logic [2:0] chan_id_t;
endpackage : timer_event_pkg

// >>> rtl/status_flag_cell.sv
`timescale 1ns/100ps
`include "timer_event_defines.svh"
// one status flag with read-then-write-0 clearing
module status_flag_cell (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic set_i, // hardware event
    input wire logic rd_i, // software read of the status flags
    input wire logic clr_wr_i, // software write of 0 to this flag
    input wire logic xfer_clr_i, // transfer controller service
    output logic flag_o,
    output logic flag_next_o
);
    logic flag_q; // the flag itself
    logic armed_q; // flag was read as 1 since the last write of 0 to it
    logic flag_d;
    logic armed_d;
    logic clear_ok;

    // a software clear only counts after a read of 1
    assign clear_ok = (clr_wr_i & armed_q) | xfer_clr_i; // see [R16] see [R17]
    // set wins over any clear in the same cycle
    assign flag_d = set_i | (flag_q & ~clear_ok); // see [R18]
    // arm on a read of 1, disarm on a write of 0 to this flag or when the flag falls
    assign armed_d = flag_q & ((rd_i) | (armed_q & ~clr_wr_i));
    assign flag_o = flag_q;
    assign flag_next_o = flag_d;

    // flag and arming state
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            flag_q <= `FLAG_RST;
            armed_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
            armed_q <= armed_d;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    AST_CLEAR_NEEDS_READ: assert property ( // see [R16]
        (flag_q && clr_wr_i && !armed_q && !xfer_clr_i) |=> flag_q)
        else $error("flag cleared without a prior read of 1");
    AST_SET_WINS: assert property ( // see [R18]
        set_i |=> flag_q)
        else $error("event lost against a clear");
endmodule : status_flag_cell

// >>> rtl/timer_event_request_logic.sv
`timescale 1ns/100ps
`include "timer_event_defines.svh"
// Function
// [R1] each source has own flag and enable
// [R2] event sets flag; request only when enabled
// [R3] request holds until flag returns to 0
// [R4] in channel: A, B, C, D, overflow, underflow
// [R5] default channel order 0 highest to 4
// [R6] sixteen match requests: 4,2,2,4,4 per channel
// [R7] one overflow request per channel
// [R8] underflow requests on channels 1 and 2 only
// [R9] seventeen transfer sources: matches plus ch4 overflow
// [R10] register A match with trigger enable starts converter
// [R11] converter starts only if timer trigger selected
// [R12] match raised in last state before update
// [R13] match drives pin to selected level
// [R14] no repeat match before next count clock
// [R15] wrap FFFF to 0000 sets overflow flag
// [R16] clear only by write 0 after read 1
// [R17] transfer service clears its flag automatically
// [R18] write 1 ignored; set beats clear
module timer_event_request_logic (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // counter input clocks, one per channel
    input wire logic [`CH_NUM-1:0] count_tick_i,
    // count direction of channels 1 and 2, high counts down
    input wire logic [`UNF_NUM-1:0] count_down_i,
    // compare values, source k at bits k*16 +: 16
    input wire logic [`MATCH_NUM*`CNT_W-1:0] general_compare_capture_reg_i,
    // input capture events per match source
    input wire logic [`MATCH_NUM-1:0] capture_evt_i,
    // pin level code per match source, two bits each
    input wire logic [2*`MATCH_NUM-1:0] pin_io_control_reg_i,
    // enable bits of the interrupt enable registers
    input wire logic [`MATCH_NUM-1:0] match_irq_enable_i,
    input wire logic [`OVF_NUM-1:0] overflow_irq_enable_i,
    input wire logic [`UNF_NUM-1:0] underflow_irq_enable_i,
    input wire logic [`CH_NUM-1:0] adc_trigger_enable_i,
    // software access to the status flags
    input wire logic flags_rd_i,
    input wire logic flags_wr_i,
    input wire logic [`MATCH_NUM+`OVF_NUM+`UNF_NUM-1:0] flags_wdata_i,
    // transfer controller service acknowledge
    input wire logic [`XFER_NUM-1:0] xfer_ack_i,
    // outputs
    output logic [`MATCH_NUM-1:0] match_irq_o,
    output logic [`OVF_NUM-1:0] overflow_irq_o,
    output logic [`UNF_NUM-1:0] underflow_irq_o,
    output logic [`XFER_NUM-1:0] xfer_req_o,
    output logic [`CH_NUM-1:0] adc_start_o,
    output logic [`MATCH_NUM-1:0] timer_io_pin_o,
    output logic [3*`CH_NUM-1:0] chan_src_o,
    output logic [2:0] top_chan_o,
    output logic top_valid_o,
    output logic [`MATCH_NUM+`OVF_NUM+`UNF_NUM-1:0] timer_status_flags_o
);
    localparam int FLAG_NUM = `MATCH_NUM + `OVF_NUM + `UNF_NUM;

    // channel that owns match source k
    function automatic int match_chan(input int k);
        if (k < 4) begin
            return 0;
        end else if (k < 6) begin
            return 1;
        end else if (k < 8) begin
            return 2;
        end else if (k < 12) begin
            return 3;
        end else begin
            return 4;
        end
    endfunction : match_chan

    // first match source of channel c (register A)
    function automatic int chan_base(input int c);
        case (c)
            0: return 0;
            1: return 4;
            2: return 6;
            3: return 8;
            default: return 12;
        endcase
    endfunction : chan_base

    // fixed priority pick inside one channel
    function automatic timer_event_pkg::pend_src_t first_src(input logic [5:0] req);
        if (req[0]) begin
            return timer_event_pkg::SRC_A;
        end else if (req[1]) begin
            return timer_event_pkg::SRC_B;
        end else if (req[2]) begin
            return timer_event_pkg::SRC_C;
        end else if (req[3]) begin
            return timer_event_pkg::SRC_D;
        end else if (req[4]) begin
            return timer_event_pkg::SRC_OVF;
        end else if (req[5]) begin
            return timer_event_pkg::SRC_UNF;
        end else begin
            return timer_event_pkg::SRC_NONE;
        end
    endfunction : first_src

    logic [`CNT_W-1:0] timer_count_q [`CH_NUM]; // per-channel counters
    logic [`CH_NUM-1:0] chan_down; // direction per channel
    logic [`MATCH_NUM-1:0] match_evt; // compare match pulses
    logic [`MATCH_NUM-1:0] match_set; // match or capture
    logic [`OVF_NUM-1:0] ovf_evt; // overflow pulses
    logic [`UNF_NUM-1:0] unf_evt; // underflow pulses
    logic [FLAG_NUM-1:0] flag_set; // all set pulses
    logic [FLAG_NUM-1:0] flag_clr_wr; // write of 0 per flag
    logic [FLAG_NUM-1:0] flag_xfer_clr; // service clear per flag
    logic [FLAG_NUM-1:0] flag_q; // flags now
    logic [FLAG_NUM-1:0] flag_d; // flags next cycle
    logic [`MATCH_NUM-1:0] match_irq_d;
    logic [`OVF_NUM-1:0] ovf_irq_d;
    logic [`UNF_NUM-1:0] unf_irq_d;
    logic [`XFER_NUM-1:0] xfer_req_d;
    logic [`CH_NUM-1:0] adc_start_d;
    logic [`MATCH_NUM-1:0] pin_d;
    logic [5:0] chan_req [`CH_NUM]; // per channel {unf, ovf, D, C, B, A}
    logic [3*`CH_NUM-1:0] chan_src_d;
    logic [2:0] top_chan_d;
    logic top_valid_d;

    // only channels 1 and 2 may count down
    assign chan_down = {2'b00, count_down_i, 1'b0};

    // counters and overflow per channel
    for (genvar c = 0; c < `CH_NUM; c++) begin : g_chan
        // wrap from max to zero counting up
        assign ovf_evt[c] = count_tick_i[c] & ~chan_down[c]
            & (timer_count_q[c] == `CNT_MAX); // see [R7] see [R15]
        // count on each counter input clock
        always_ff @(posedge clk_sys_i) begin
            if (rst_i) begin
                timer_count_q[c] <= `CNT_MIN;
            end else if (count_tick_i[c] && chan_down[c]) begin
                timer_count_q[c] <= timer_count_q[c] - `CNT_ONE;
            end else if (count_tick_i[c]) begin
                timer_count_q[c] <= timer_count_q[c] + `CNT_ONE;
            end
        end
    end

    // underflow exists on channels 1 and 2 only
    for (genvar u = 0; u < `UNF_NUM; u++) begin : g_unf
        assign unf_evt[u] = count_tick_i[u+1] & count_down_i[u]
            & (timer_count_q[u+1] == `CNT_MIN); // see [R8]
    end

    // compare match and pin per match source
    for (genvar k = 0; k < `MATCH_NUM; k++) begin : g_match
        localparam int CH = match_chan(k);
        logic [1:0] lvl; // selected pin level code
        // match only in the state where the counter is about to update,
        // so one counter value yields one match per count clock
        assign match_evt[k] = count_tick_i[CH]
            & (timer_count_q[CH] == general_compare_capture_reg_i[k*`CNT_W +: `CNT_W]); // see [R12] see [R14]
        assign match_set[k] = match_evt[k] | capture_evt_i[k]; // see [R6]
        assign lvl = pin_io_control_reg_i[2*k +: 2];
        // drive the pin as selected on a match
        assign pin_d[k] = !match_evt[k] ? timer_io_pin_o[k]
            : (lvl == `PIN_LOW) ? 1'b0
            : (lvl == `PIN_HIGH) ? 1'b1
            : (lvl == `PIN_TOGGLE) ? ~timer_io_pin_o[k]
            : timer_io_pin_o[k]; // see [R13]
    end

    // flag order: matches, then overflows, then underflows
    assign flag_set = {unf_evt, ovf_evt, match_set};
    // writing 1 leaves a flag alone
    assign flag_clr_wr = {FLAG_NUM{flags_wr_i}} & ~flags_wdata_i; // see [R18]
    // service of a transfer source clears only that source's flag
    assign flag_xfer_clr = {{`UNF_NUM{1'b0}}, xfer_ack_i[`XFER_NUM-1],
        {(`OVF_NUM-1){1'b0}}, xfer_ack_i[`MATCH_NUM-1:0]}; // see [R17] see [R9]

    // one flag cell per source
    for (genvar f = 0; f < FLAG_NUM; f++) begin : g_flag
        status_flag_cell u_cell (
            .clk_sys_i(clk_sys_i),
            .rst_i(rst_i),
            .set_i(flag_set[f]),
            .rd_i(flags_rd_i),
            .clr_wr_i(flag_clr_wr[f]),
            .xfer_clr_i(flag_xfer_clr[f]),
            .flag_o(flag_q[f]),
            .flag_next_o(flag_d[f])
        ); // see [R1]
    end

    // request follows flag and its own enable, drops with the flag
    assign match_irq_d = flag_d[`MATCH_NUM-1:0] & match_irq_enable_i; // see [R2] see [R3]
    assign ovf_irq_d = flag_d[`MATCH_NUM +: `OVF_NUM] & overflow_irq_enable_i; // see [R7]
    assign unf_irq_d = flag_d[`MATCH_NUM+`OVF_NUM +: `UNF_NUM] & underflow_irq_enable_i; // see [R8]
    // transfer sources: all match requests plus channel 4 overflow
    assign xfer_req_d = {ovf_irq_d[`OVF_NUM-1], match_irq_d}; // see [R9]

    // per channel request groups and converter triggers
    for (genvar c = 0; c < `CH_NUM; c++) begin : g_prio
        localparam int B = chan_base(c);
        // register A match with trigger enable starts a conversion
        assign adc_start_d[c] = match_set[B] & adc_trigger_enable_i[c]; // see [R10]
        if (c == 1 || c == 2) begin : g_two
            assign chan_req[c] = {unf_irq_d[c-1], ovf_irq_d[c], 2'b00, match_irq_d[B+1], match_irq_d[B]};
        end else begin : g_four
            assign chan_req[c] = {1'b0, ovf_irq_d[c], match_irq_d[B+3:B]};
        end
        // fixed order inside the channel
        assign chan_src_d[3*c +: 3] = first_src(chan_req[c]); // see [R4]
    end

    // default channel order: lowest channel number wins
    assign top_valid_d = (chan_req[0] != 6'h00) | (chan_req[1] != 6'h00) | (chan_req[2] != 6'h00)
        | (chan_req[3] != 6'h00) | (chan_req[4] != 6'h00);
    assign top_chan_d = (chan_req[0] != 6'h00) ? 3'h0
        : (chan_req[1] != 6'h00) ? 3'h1
        : (chan_req[2] != 6'h00) ? 3'h2
        : (chan_req[3] != 6'h00) ? 3'h3
        : 3'h4; // see [R5]

    // all outputs straight from flops
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            match_irq_o <= '0;
            overflow_irq_o <= '0;
            underflow_irq_o <= '0;
            xfer_req_o <= '0;
            adc_start_o <= '0;
            timer_io_pin_o <= {`MATCH_NUM{`PIN_RST}};
            chan_src_o <= {`CH_NUM{timer_event_pkg::SRC_NONE}};
            top_chan_o <= 3'h0;
            top_valid_o <= 1'b0;
            timer_status_flags_o <= '0;
        end else begin
            match_irq_o <= match_irq_d;
            overflow_irq_o <= ovf_irq_d;
            underflow_irq_o <= unf_irq_d;
            xfer_req_o <= xfer_req_d;
            adc_start_o <= adc_start_d;
            timer_io_pin_o <= pin_d;
            chan_src_o <= chan_src_d;
            top_chan_o <= top_chan_d;
            top_valid_o <= top_valid_d;
            timer_status_flags_o <= flag_d;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    // overflow step: counter at max with an up count clock
    sequence s_wrap0;
        count_tick_i[0] && (timer_count_q[0] == `CNT_MAX);
    endsequence
    sequence s_ovf_seen0;
        timer_status_flags_o[`MATCH_NUM] && (timer_count_q[0] == `CNT_MIN);
    endsequence
    // underflow step on channel 1
    sequence s_under1;
        count_tick_i[1] && count_down_i[0] && (timer_count_q[1] == `CNT_MIN);
    endsequence

    AST_IRQ_NEEDS_ENABLE: assert property ( // see [R2]
        match_irq_o[0] |-> timer_status_flags_o[0] && $past(match_irq_enable_i[0]))
        else $error("match request without flag and enable");
    AST_IRQ_DROPS_WITH_FLAG: assert property ( // see [R3]
        $fell(timer_status_flags_o[1]) |-> !match_irq_o[1])
        else $error("request still up after flag cleared");
    AST_OVF_WRAP: assert property ( // see [R15]
        s_wrap0 |=> s_ovf_seen0)
        else $error("overflow flag not set on wrap");
    AST_OVF_IRQ: assert property ( // see [R7]
        (s_wrap0 ##0 overflow_irq_enable_i[0]) |=> overflow_irq_o[0])
        else $error("overflow request missing");
    AST_UNF_IRQ: assert property ( // see [R8]
        (s_under1 ##0 underflow_irq_enable_i[0]) |=> underflow_irq_o[0] ##0 timer_status_flags_o[21])
        else $error("underflow request missing");
    AST_ADC_START: assert property ( // see [R10]
        (match_set[4] && adc_trigger_enable_i[1]) |=> adc_start_o[1] ##1 !adc_start_o[1] || $past(match_set[4]))
        else $error("converter start not a pulse on register A match");
    AST_XFER_CH4_OVF: assert property ( // see [R9]
        xfer_req_o[16] |-> timer_status_flags_o[20] && $past(overflow_irq_enable_i[4]))
        else $error("transfer request from wrong source");
    AST_PRIO_A_FIRST: assert property ( // see [R4]
        match_irq_o[0] |-> chan_src_o[2:0] == timer_event_pkg::SRC_A)
        else $error("register A not highest inside channel 0");
    AST_CH0_TOP: assert property ( // see [R5]
        (match_irq_o[0] || overflow_irq_o[0]) |-> top_valid_o && top_chan_o == 3'h0)
        else $error("channel 0 not highest by default");
    AST_PIN_HIGH: assert property ( // see [R13]
        (match_evt[0] && pin_io_control_reg_i[1:0] == `PIN_HIGH) |=> timer_io_pin_o[0])
        else $error("pin not driven high on match");
    AST_ONE_MATCH_PER_TICK: assert property ( // see [R14]
        match_evt[0] |-> count_tick_i[0])
        else $error("match without a count clock");
    AST_XFER_CLEARS: assert property ( // see [R17]
        (xfer_ack_i[0] && !match_set[0]) |=> !timer_status_flags_o[0] ##1 !match_irq_o[0] || $past(match_set[0]))
        else $error("transfer service did not clear flag");
endmodule : timer_event_request_logic

// >>> test/timer_far_side_model.sv
`timescale 1ns/100ps
// transfer controller and converter seen from the timer
module timer_far_side_model #(
    parameter int SERVICE_DELAY = 3 // cycles before a request is served
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic service_en_i, // transfer controller enabled
    input wire logic adc_sel_i, // converter has timer trigger selected
    input wire logic [16:0] xfer_req_i,
    input wire logic [4:0] adc_start_i,
    output logic [16:0] xfer_ack_o,
    output logic [7:0] adc_conv_count_o
);
    int wait_q; // service latency counter
    wire logic [16:0] lowest = xfer_req_i & (~xfer_req_i + 17'h00001); // lowest pending source
    // serve one source at a time, never twice back to back
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            wait_q <= 0;
            xfer_ack_o <= 17'h00000;
        end else begin
            xfer_ack_o <= 17'h00000;
            if (service_en_i && (|xfer_req_i) && !(|xfer_ack_o)) begin
                // ack pulse clears the served flag
                if (wait_q == SERVICE_DELAY) begin
                    xfer_ack_o <= lowest;
                    wait_q <= 0;
                end else begin
                    wait_q <= wait_q + 1;
                end
            end else begin
                wait_q <= 0;
            end
        end
    end
    // conversions start only with the timer trigger selected
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            adc_conv_count_o <= 8'h00;
        end else if (adc_sel_i) begin
            adc_conv_count_o <= adc_conv_count_o + 8'($countones(adc_start_i));
        end
    end
endmodule : timer_far_side_model

// >>> test/tb_timer_event_request_logic.sv
`timescale 1ns/100ps
// bench of the timer event request logic
module tb_timer_event_request_logic;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic [4:0] count_tick_i = 5'h00, overflow_irq_enable_i = 5'h00, adc_trigger_enable_i = 5'h00;
    logic [1:0] count_down_i = 2'h0, underflow_irq_enable_i = 2'h0;
    logic [255:0] general_compare_capture_reg_i = {16{16'hFFFF}};
    logic [15:0] capture_evt_i = 16'h0000, match_irq_enable_i = 16'h0000;
    logic [31:0] pin_io_control_reg_i = 32'h00000000;
    logic flags_rd_i = 1'b0, flags_wr_i = 1'b0, service_en = 1'b0, adc_sel = 1'b0;
    logic [22:0] flags_wdata_i = 23'h000000, timer_status_flags_o;
    logic [16:0] xfer_ack_i, xfer_req_o;
    logic [15:0] match_irq_o, timer_io_pin_o;
    logic [4:0] overflow_irq_o, adc_start_o;
    logic [1:0] underflow_irq_o;
    logic [14:0] chan_src_o;
    logic [2:0] top_chan_o;
    logic top_valid_o;
    logic [7:0] adc_count; // conversions seen by the converter
    int mismatches = 0, tests_run = 0;
    typedef struct packed {logic [3:0] src; logic en; logic req;} row_t; // source, enable, expected request
    row_t rows [0:7];
    // clock of 8 ns
    initial begin
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    timer_event_request_logic dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .count_tick_i(count_tick_i),
        .count_down_i(count_down_i), .general_compare_capture_reg_i(general_compare_capture_reg_i),
        .capture_evt_i(capture_evt_i), .pin_io_control_reg_i(pin_io_control_reg_i),
        .match_irq_enable_i(match_irq_enable_i), .overflow_irq_enable_i(overflow_irq_enable_i),
        .underflow_irq_enable_i(underflow_irq_enable_i), .adc_trigger_enable_i(adc_trigger_enable_i),
        .flags_rd_i(flags_rd_i), .flags_wr_i(flags_wr_i), .flags_wdata_i(flags_wdata_i),
        .xfer_ack_i(xfer_ack_i), .match_irq_o(match_irq_o), .overflow_irq_o(overflow_irq_o),
        .underflow_irq_o(underflow_irq_o), .xfer_req_o(xfer_req_o), .adc_start_o(adc_start_o),
        .timer_io_pin_o(timer_io_pin_o), .chan_src_o(chan_src_o), .top_chan_o(top_chan_o),
        .top_valid_o(top_valid_o), .timer_status_flags_o(timer_status_flags_o));
    timer_far_side_model far_side (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .service_en_i(service_en),
        .adc_sel_i(adc_sel), .xfer_req_i(xfer_req_o), .adc_start_i(adc_start_o), .xfer_ack_o(xfer_ack_i),
        .adc_conv_count_o(adc_count));
    // verdict and end of run
    task test_done();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done
    // value compare
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    // let n edges pass, then sample mid cycle
    task settle(input int n);
        repeat (n) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
    endtask : settle
    task pulse_cap(input logic [15:0] m);
        @(posedge clk_sys_i) capture_evt_i <= m;
        @(posedge clk_sys_i) capture_evt_i <= 16'h0000;
    endtask : pulse_cap
    task ticks(input logic [4:0] m, input int n);
        @(posedge clk_sys_i) count_tick_i <= m;
        repeat (n - 1) @(posedge clk_sys_i);
        @(posedge clk_sys_i) count_tick_i <= 5'h00;
    endtask : ticks
    // read strobe, then write strobe two cycles later
    task sw_clear(input logic [22:0] w);
        @(posedge clk_sys_i) flags_rd_i <= 1'b1;
        @(posedge clk_sys_i) flags_rd_i <= 1'b0;
        @(posedge clk_sys_i) begin
            flags_wr_i <= 1'b1;
            flags_wdata_i <= w;
        end
        @(posedge clk_sys_i) flags_wr_i <= 1'b0;
    endtask : sw_clear
    task wait_clear();
        int n;
        n = 0;
        while (timer_status_flags_o !== 23'h000000 && n < 20) begin
            @(negedge clk_sys_i);
            n++;
        end
        if (n == 20) begin
            mismatches++;
            $display("mismatch at %0t: flag never cleared", $time);
            test_done();
        end
    endtask : wait_clear
    // main sequence
    initial begin
        rows = '{'{4'h0, 1'b1, 1'b1}, '{4'h3, 1'b0, 1'b0}, '{4'h4, 1'b1, 1'b1}, '{4'h5, 1'b0, 1'b0},
                 '{4'h7, 1'b1, 1'b1}, '{4'h8, 1'b0, 1'b0}, '{4'hB, 1'b1, 1'b1}, '{4'hF, 1'b1, 1'b1}};
        repeat (12) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        settle(1);
        chk(32'(chan_src_o), 32'h00007FFF, "reset source");
        chk(32'(top_valid_o), 32'h0, "reset top");
        // table of single capture events
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys_i) match_irq_enable_i <= 16'(rows[i].en) << rows[i].src;
            pulse_cap(16'h0001 << rows[i].src);
            settle(3);
            chk(32'(timer_status_flags_o), 32'h1 << rows[i].src, "row flag");
            chk(32'(match_irq_o), 32'(rows[i].req) << rows[i].src, "row request");
            chk(32'(xfer_req_o), 32'(rows[i].req) << rows[i].src, "row transfer");
            if (rows[i].en) begin
                @(posedge clk_sys_i) service_en <= 1'b1;
                wait_clear();
                @(posedge clk_sys_i) service_en <= 1'b0;
            end else begin
                sw_clear(23'h000000);
            end
            settle(2);
            chk(32'(timer_status_flags_o), 32'h0, "row cleared");
            chk(32'(match_irq_o), 32'h0, "row withdrawn");
        end
        $display("test rows done");
        // clearing without a read, by writing 1, and against a set
        @(posedge clk_sys_i) match_irq_enable_i <= 16'h0001;
        pulse_cap(16'h0001);
        @(posedge clk_sys_i) flags_wr_i <= 1'b1;
        @(posedge clk_sys_i) flags_wr_i <= 1'b0;
        settle(2);
        chk(32'(timer_status_flags_o), 32'h1, "write without read");
        sw_clear(23'h7FFFFF);
        settle(2);
        chk(32'(timer_status_flags_o), 32'h1, "write of one");
        @(posedge clk_sys_i) flags_rd_i <= 1'b1;
        @(posedge clk_sys_i) flags_rd_i <= 1'b0;
        @(posedge clk_sys_i) begin
            flags_wr_i <= 1'b1;
            flags_wdata_i <= 23'h000000;
            capture_evt_i <= 16'h0001;
        end
        @(posedge clk_sys_i) begin
            flags_wr_i <= 1'b0;
            capture_evt_i <= 16'h0000;
        end
        settle(2);
        chk(32'(timer_status_flags_o), 32'h1, "set beats clear");
        sw_clear(23'h000000);
        settle(2);
        chk(32'(match_irq_o), 32'h0, "cleared request");
        $display("test clearing done");
        // priority inside and across channels
        @(posedge clk_sys_i) match_irq_enable_i <= 16'hFFFF;
        pulse_cap(16'h0046);
        settle(3);
        chk(32'(chan_src_o[2:0]), 32'h1, "ch0 source b");
        chk(32'(chan_src_o[8:6]), 32'h0, "ch2 source a");
        chk(32'({top_valid_o, top_chan_o}), 32'h8, "top ch0");
        sw_clear(23'h7FFFFD);
        settle(3);
        chk(32'(chan_src_o[2:0]), 32'h2, "ch0 source c");
        sw_clear(23'h7FFFFB);
        settle(3);
        chk(32'(chan_src_o[2:0]), 32'h7, "ch0 none");
        chk(32'({top_valid_o, top_chan_o}), 32'hA, "top ch2");
        sw_clear(23'h000000);
        $display("test priority done");
        // compare match, pin codes high toggle low keep, converter start
        @(posedge clk_sys_i) begin
            general_compare_capture_reg_i[63:0] <= {4{16'h0002}};
            pin_io_control_reg_i <= 32'h0000001E;
            adc_trigger_enable_i <= 5'h01;
            adc_sel <= 1'b1;
            match_irq_enable_i <= 16'h0000;
        end
        ticks(5'h01, 2);
        settle(3);
        chk(32'(timer_status_flags_o), 32'h0, "no early match");
        ticks(5'h01, 1);
        settle(3);
        chk(32'(timer_status_flags_o), 32'hF, "match flags");
        chk(32'(timer_io_pin_o[3:0]), 32'h3, "pin levels");
        chk(32'(adc_count), 32'h1, "converter start");
        sw_clear(23'h000000);
        settle(5);
        chk(32'(timer_status_flags_o), 32'h0, "no repeat match");
        @(posedge clk_sys_i) adc_sel <= 1'b0;
        pulse_cap(16'h0001);
        settle(3);
        chk(32'(adc_count), 32'h1, "trigger not selected");
        @(posedge clk_sys_i) adc_sel <= 1'b1;
        pulse_cap(16'h0010);
        settle(3);
        chk(32'(adc_count), 32'h1, "ch1 trigger off");
        @(posedge clk_sys_i) adc_trigger_enable_i <= 5'h02;
        pulse_cap(16'h0010);
        settle(3);
        chk(32'(adc_count), 32'h2, "ch1 trigger on");
        sw_clear(23'h000000);
        $display("test compare done");
        // underflow of ch1 counting down from zero
        @(posedge clk_sys_i) begin
            count_down_i <= 2'h1;
            underflow_irq_enable_i <= 2'h1;
        end
        ticks(5'h02, 1);
        settle(3);
        chk(32'(timer_status_flags_o[22:16]), 32'h20, "underflow flag");
        chk(32'(underflow_irq_o), 32'h1, "underflow request");
        sw_clear(23'h000000);
        settle(2);
        chk(32'(underflow_irq_o), 32'h0, "underflow withdrawn");
        $display("test underflow done");
        // every counter wraps once
        @(posedge clk_sys_i) begin
            count_down_i <= 2'h0;
            overflow_irq_enable_i <= 5'h15;
        end
        ticks(5'h1F, 65536);
        settle(3);
        chk(32'(timer_status_flags_o[22:16]), 32'h1F, "overflow flags");
        chk(32'(overflow_irq_o), 32'h15, "overflow requests");
        chk(32'(xfer_req_o), 32'h10000, "ch4 overflow transfer");
        chk(32'({top_valid_o, top_chan_o}), 32'h8, "top ch0 overflow");
        @(posedge clk_sys_i) overflow_irq_enable_i <= 5'h14;
        settle(3);
        chk(32'({top_valid_o, top_chan_o}), 32'hA, "top ch2 overflow");
        $display("test overflow done");
        // reset in mid run
        @(posedge clk_sys_i) rst_i <= 1'b1;
        settle(2);
        chk(32'(timer_status_flags_o), 32'h0, "flags in reset");
        chk(32'({top_valid_o, chan_src_o}), 32'h7FFF, "sources in reset");
        @(posedge clk_sys_i) rst_i <= 1'b0;
        $display("test reset done");
        test_done();
    end
endmodule : tb_timer_event_request_logic
